// ---- hw/ptc_timer.sv ----
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - reset clears present value to zero
// - reset active keeps timing halted, outputs off
// - reset indicator lit by input or key
// - reset key acts like external reset
// - two reset terminals, either one resets
// - forecast mode: second output at set value
// - forecast mode: first output at difference
// - forecast not below set value: immediate
// - absolute mode: first output at value one
// - absolute mode: second output at value two
// - output indicator segments follow both outputs
// - decimal point blinks while timing, tenth ranges
// - protect switch blocks enabled key operations
// - protect switch sampled continuously
// - protect indicator lit while switch on
module ptc_timer
  import ptc_pkg::*;
#(
  parameter int unsigned BASE_TICK_CYCLES = BASE_TICK_CYC  // shorten for simulation
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        START_IN,
  input  wire logic        GATE_IN,
  input  wire logic        RESET_A_IN,
  input  wire logic        RESET_B_IN,
  input  wire logic        RESET_KEY,
  input  wire logic        UP_KEY,
  input  wire logic        MODE_KEY,
  input  wire logic        KEY_PROTECT_SW,
  output logic             FIRST_OUTPUT,
  output logic             SECOND_OUTPUT,
  output logic [1:0]       OUT_IND,
  output logic             RESET_IND,
  output logic             KEY_PROT_IND,
  output logic             PV_DP,
  output logic             UP_KEY_OK,
  output logic             MODE_KEY_OK
);
  // reset release through two flops
  logic rst_q1_r;
  logic rst_n;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  // pin synchronisers; the protect switch is sampled every cycle
  ptc_pins_s pins_raw;  // raw terminal and key levels
  ptc_pins_s pins_s;    // synchronised copy
  assign pins_raw = {START_IN, GATE_IN, RESET_A_IN, RESET_B_IN,
                     RESET_KEY, UP_KEY, MODE_KEY, KEY_PROTECT_SW};
  ptc_sync #(.W(8)) u_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // registers and state
  ptc_ctrl_s         ctrl_r;      // configuration
  logic [PV_W-1:0]   sv_main_r;   // set value / set value 2
  logic [PV_W-1:0]   sv_aux_r;    // forecast set value / set value 1
  logic [PV_W-1:0]   pv_r;        // present value
  ptc_state_e        state_r;     // idle or timing
  logic              start_d_r;   // start level delayed for edge
  logic [20:0]       base_cnt_r;  // base step divider
  logic [15:0]       pre_r;       // range prescaler
  logic [6:0]        blink_cnt_r; // blink half-period counter
  logic              blink_r;     // blink phase
  logic              first_r;     // first output level
  logic              second_r;    // second output level
  logic              rst_ind_r;
  logic              kp_ind_r;
  logic              dp_r;
  logic              up_ok_r;
  logic              mode_ok_r;
  logic [31:0]       prdata_r;

  // apb decode
  wire        wr_en    = PSEL & PENABLE & PWRITE;
  wire        hit_ctrl = (PADDR == OFS_CTRL);
  wire        hit_main = (PADDR == OFS_SVMAIN);
  wire        hit_aux  = (PADDR == OFS_SVAUX);
  wire        hit_pv   = (PADDR == OFS_PV);
  wire        hit_stat = (PADDR == OFS_STATUS);
  wire        hit_any  = hit_ctrl | hit_main | hit_aux | hit_pv | hit_stat;
  wire        wr_ctrl  = wr_en & hit_ctrl;
  ptc_ctrl_s  ctrl_wd;
  assign ctrl_wd = PWDATA[5:0];
  // a change of setting method wipes values and outputs
  wire        mode_chg = wr_ctrl & (ctrl_wd.abs_mode != ctrl_r.abs_mode);

  // reset sources: either terminal, or an unprotected reset key
  wire kp_on      = pins_s.kp_sw;
  wire rst_key_ok = pins_s.key_rst & ~(kp_on & ctrl_r.prot_rst);
  wire rst_ext    = pins_s.rst_a | pins_s.rst_b;
  wire rst_any    = rst_ext | rst_key_ok;
  wire clr_all    = rst_any | mode_chg;

  // timing control
  wire start_rise = pins_s.start & ~start_d_r;
  wire go         = start_rise & ~pins_s.gate & ~rst_any;
  wire running    = (state_r == ST_RUN);
  wire counting   = running & ~pins_s.gate & ~rst_any;
  wire base_tick  = (base_cnt_r == 21'(BASE_TICK_CYCLES - 1));
  wire [15:0] range_div = (ctrl_r.range == RANGE_10MS) ? DIV_10MS :
                          (ctrl_r.range == RANGE_1S)   ? DIV_1S   :
                          (ctrl_r.range == RANGE_0M1)  ? DIV_0M1  : DIV_0H1;
  wire pre_wrap   = (pre_r == range_div - 16'h0001);
  wire pv_step    = counting & base_tick & pre_wrap & (pv_r != PV_MAX);

  // comparison thresholds; difference clamps to zero
  wire [PV_W-1:0] fc_thr   = (sv_main_r > sv_aux_r) ? sv_main_r - sv_aux_r : PV_RST;
  wire [PV_W-1:0] first_thr  = ctrl_r.abs_mode ? sv_aux_r : fc_thr;
  wire            first_hit  = running & (pv_r >= first_thr);
  wire            second_hit = running & (pv_r >= sv_main_r);
  wire            dp_range = (ctrl_r.range == RANGE_0M1) | (ctrl_r.range == RANGE_0H1);

  // read mux
  ptc_status_s status;
  assign status = {dp_r, kp_ind_r, rst_ind_r, running, second_r, first_r};
  wire [31:0] rdata = hit_ctrl ? {26'h0, ctrl_r} :
                      hit_main ? {12'h0, sv_main_r} :
                      hit_aux  ? {12'h0, sv_aux_r} :
                      hit_pv   ? {12'h0, pv_r} :
                      hit_stat ? {26'h0, status} : 32'h0;

  // apb registers; read data caught in the setup cycle for zero wait
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= CTRL_RST;
      sv_main_r <= PV_RST;
      sv_aux_r  <= PV_RST;
      prdata_r  <= 32'h0;
    end else begin
      if (PSEL & ~PENABLE) begin
        prdata_r <= rdata;
      end
      if (wr_ctrl) begin
        ctrl_r <= ctrl_wd;
      end
      if (mode_chg) begin
        sv_main_r <= PV_RST;
        sv_aux_r  <= PV_RST;
      end else if (wr_en & hit_main) begin
        sv_main_r <= PWDATA[PV_W-1:0];
      end else if (wr_en & hit_aux) begin
        sv_aux_r <= PWDATA[PV_W-1:0];
      end
    end
  end
  assign PRDATA  = prdata_r;
  assign PREADY  = 1'b1;
  // unmapped offsets answer with an error
  assign PSLVERR = PSEL & PENABLE & ~hit_any;

  // timing state; reset stops it and a new start is needed
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= pins_s.start;
      unique case (state_r)
        ST_IDLE: if (go) state_r <= ST_RUN;
        ST_RUN:  if (clr_all) state_r <= ST_IDLE;
      endcase
    end
  end

  // free-running base divider keeps the phase of the blink steady
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_r <= 21'h0;
    end else if (base_tick) begin
      base_cnt_r <= 21'h0;
    end else begin
      base_cnt_r <= base_cnt_r + 21'h1;
    end
  end

  // prescaler and present value; gate freezes both so timing resumes
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 16'h0;
      pv_r  <= PV_RST;
    end else if (clr_all) begin
      pre_r <= 16'h0;
      pv_r  <= PV_RST;
    end else if (counting & base_tick) begin
      pre_r <= pre_wrap ? 16'h0 : pre_r + 16'h1;
      if (pv_step) begin
        pv_r <= pv_r + 20'h1;
      end
    end
  end

  // outputs and indicators, all registered
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      first_r   <= 1'b0;
      second_r  <= 1'b0;
      rst_ind_r <= 1'b0;
      kp_ind_r  <= 1'b0;
      up_ok_r   <= 1'b0;
      mode_ok_r <= 1'b0;
    end else begin
      first_r   <= first_hit & ~clr_all;
      second_r  <= second_hit & ~clr_all;
      rst_ind_r <= rst_any;
      kp_ind_r  <= kp_on;
      up_ok_r   <= pins_s.key_up & ~(kp_on & ctrl_r.prot_up);
      mode_ok_r <= pins_s.key_mode & ~(kp_on & ctrl_r.prot_mode);
    end
  end
  assign FIRST_OUTPUT  = first_r;
  assign SECOND_OUTPUT = second_r;
  assign OUT_IND       = {second_r, first_r};
  assign RESET_IND     = rst_ind_r;
  assign KEY_PROT_IND  = kp_ind_r;
  assign UP_KEY_OK     = up_ok_r;
  assign MODE_KEY_OK   = mode_ok_r;

  // decimal point: steady when idle, blinks while counting in the tenth ranges
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= 7'h0;
      blink_r     <= 1'b0;
      dp_r        <= 1'b0;
    end else begin
      if (base_tick) begin
        if (blink_cnt_r == 7'(BLINK_TICKS - 1)) begin
          blink_cnt_r <= 7'h0;
          blink_r     <= ~blink_r;
        end else begin
          blink_cnt_r <= blink_cnt_r + 7'h1;
        end
      end
      dp_r <= dp_range & (counting ? blink_r : 1'b1);
    end
  end
  assign PV_DP = dp_r;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    go;
  endsequence
  sequence s_reset_held;
    rst_any [*2];
  endsequence

  AST_START_RUNS: assert property (s_start |=> running)
    else $error("start did not begin timing");
  // a reset under gate still clears, so it is left out here
  AST_GATE_HOLDS: assert property (running & pins_s.gate & !clr_all |=> $stable(pv_r))
    else $error("present value moved under gate");
  AST_RESET_ZERO: assert property (rst_any |=> pv_r == PV_RST)
    else $error("reset did not clear present value");
  AST_RESET_HALT: assert property (s_reset_held |-> !running && !second_r && !first_r)
    else $error("timing or output active under reset");
  AST_RESET_IND: assert property (rst_ext |=> RESET_IND)
    else $error("reset indicator dark during reset");
  AST_TWO_TERMINALS: assert property (pins_s.rst_b & running |=> !running && pv_r == PV_RST)
    else $error("second reset terminal ignored");
  AST_FCAST_SECOND_OUTPUT: assert property (!ctrl_r.abs_mode & second_hit & !clr_all |=> SECOND_OUTPUT)
    else $error("second output missed set value");
  AST_FCAST_EARLY: assert property (s_start ##1 (!ctrl_r.abs_mode && sv_aux_r >= sv_main_r
                     && !clr_all) |=> FIRST_OUTPUT)
    else $error("first output late with large forecast");
  AST_ABS_FIRST_OUTPUT: assert property (ctrl_r.abs_mode & running & pv_r >= sv_aux_r & !clr_all
                  |=> FIRST_OUTPUT)
    else $error("first output missed set value one");
  AST_KEY_BLOCK: assert property (kp_on & ctrl_r.prot_rst & pins_s.key_rst & !rst_ext
                   |=> !RESET_IND)
    else $error("protected reset key acted");
  AST_KP_IND: assert property (kp_on |=> KEY_PROT_IND)
    else $error("protect indicator dark");
  // forecast threshold rebuilt from the set values, not from the design's own wire
  AST_FCAST_FIRST_OUTPUT: assert property (!ctrl_r.abs_mode & running & !clr_all
                    & sv_main_r > sv_aux_r & pv_r >= sv_main_r - sv_aux_r |=> FIRST_OUTPUT)
    else $error("first output missed forecast value");
  AST_ABS_SECOND_OUTPUT: assert property (ctrl_r.abs_mode & running & !clr_all
                  & pv_r >= sv_main_r |=> SECOND_OUTPUT)
    else $error("second output missed set value two");
  AST_KEY_RESET: assert property (pins_s.key_rst & !(kp_on & ctrl_r.prot_rst)
                   |=> RESET_IND && pv_r == PV_RST && !FIRST_OUTPUT && !SECOND_OUTPUT)
    else $error("reset key did not clear");
  AST_DP_DARK: assert property (!dp_range |=> !PV_DP)
    else $error("point lit outside tenth ranges");
  AST_KP_LIVE: assert property (!kp_on & pins_s.key_up |=> UP_KEY_OK)
    else $error("up key held off with switch off");
endmodule

// ---- pkg/ptc_pkg.sv ----
package ptc_pkg;
  // clock and timebase
  localparam int CLK_PERIOD_NS = 5;                             // 200 MHz core clock
  localparam int BASE_TICK_NS  = 10_000_000;                    // 0.01 s base step
  localparam int BASE_TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS;  // cycles per base step
  localparam int BLINK_TICKS   = 50;                            // half period of dp blink
  // base steps per present-value count, one per time range
  localparam logic [15:0] DIV_10MS = 16'h0001;                  // 0.01 s
  localparam logic [15:0] DIV_1S   = 16'h0064;                  // 1 s (h:m:s range)
  localparam logic [15:0] DIV_0M1  = 16'h0258;                  // 0.1 min
  localparam logic [15:0] DIV_0H1  = 16'h8CA0;                  // 0.1 h
  // time range codes {switch 2, switch 1}
  localparam logic [1:0] RANGE_0H1  = 2'h0;
  localparam logic [1:0] RANGE_10MS = 2'h1;
  localparam logic [1:0] RANGE_1S   = 2'h2;
  localparam logic [1:0] RANGE_0M1  = 2'h3;
  // present value: six digits
  localparam int          PV_W   = 20;
  localparam logic [19:0] PV_MAX = 20'hF423F;
  localparam logic [19:0] PV_RST = 20'h00000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SVMAIN = 8'h04;
  localparam logic [7:0] OFS_SVAUX  = 8'h08;
  localparam logic [7:0] OFS_PV     = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control register layout, low bits upward: abs_mode, range, protect bits
  typedef struct packed {
    logic       prot_mode;  // mode key protected when switch on
    logic       prot_up;    // up keys protected when switch on
    logic       prot_rst;   // reset key protected when switch on
    logic [1:0] range;      // time range code
    logic       abs_mode;   // 1 absolute setting, 0 forecast setting
  } ptc_ctrl_s;
  localparam ptc_ctrl_s CTRL_RST = 6'h00;
  // status register layout, high bits downward
  typedef struct packed {
    logic dp;       // decimal point drive
    logic kp_ind;   // key protection indicator
    logic rst_ind;  // reset indicator
    logic running;  // timing in progress
    logic second_out;  // second output
    logic first_out;   // first output
  } ptc_status_s;
  // synchronised front-panel and terminal inputs
  typedef struct packed {
    logic start;
    logic gate;
    logic rst_a;
    logic rst_b;
    logic key_rst;
    logic key_up;
    logic key_mode;
    logic kp_sw;
  } ptc_pins_s;
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} ptc_state_e;
endpackage

// ---- hw/ptc_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser bank for asynchronous pins
module ptc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // per-bit pair; the first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_r;  // first stage, metastability absorber
    logic stab_r;  // second stage, safe to read
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r <= 1'b0;
        stab_r <= 1'b0;
      end else begin
        meta_r <= d[i];
        stab_r <= meta_r;
      end
    end
    assign q[i] = stab_r;
  end
endmodule

// ---- verification/ptc_pins_model.sv ----
`timescale 1ns/1ps
// stand-in for the sensors, contacts and keys wired to the terminals
module ptc_pins_model
  import ptc_pkg::*;
(
  input  wire logic      clk,
  input  wire ptc_pins_s cmd,   // levels the bench asks for
  input  wire logic      slow,  // contact settles one clock later
  output ptc_pins_s      pins   // levels seen on the terminals
);
  ptc_pins_s lvl_r  = '0;  // first settle stage
  ptc_pins_s lvl2_r = '0;  // second stage for slow contacts
  // a contact never moves in the same step as the request, avoiding races
  always @(posedge clk) begin
    lvl_r  <= cmd;
    lvl2_r <= lvl_r;
  end
  // slow changes one clock after start falls, while only start still differs between the stages, so no glitch
  assign pins = slow ? lvl2_r : lvl_r;
endmodule

// ---- verification/preset_time_comparator_io_bench.sv ----
`timescale 1ns/1ps
// self-checking bench: APB master on one side, terminal model on the other
module preset_time_comparator_io_bench;
  import ptc_pkg::*;
  localparam int TICK = 4;        // shortened base step keeps the run brief
  logic        CLK     = 1'b0;
  logic        RSTN    = 1'b0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [7:0]  PADDR   = 8'h00;
  logic [31:0] PWDATA  = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, FIRST_OUTPUT, SECOND_OUTPUT, RESET_IND;
  logic        KEY_PROT_IND, PV_DP, UP_KEY_OK, MODE_KEY_OK;
  logic [1:0]  OUT_IND;
  ptc_pins_s   pins;              // terminal levels from the model
  ptc_pins_s   cmd     = '0;      // levels requested by the bench
  logic        slow    = 1'b0;    // model answer speed
  logic        rd_chk  = 1'b0;    // this read is compared
  logic        pin_chk = 1'b0;    // outputs compared this cycle
  logic [32:0] rd_q[$];           // expected {error, data}
  logic [7:0]  pin_q[$];          // expected output vector
  logic [31:0] rd_val;            // data of the last read
  logic [7:0]  rnd     = 8'h62;   // random state, seed 98
  logic        dp_p;              // previous decimal point level
  int          fails       = 0;
  int          comparisons = 0;
  int          thr1, thr2, dp_chg;
  int          svm[3] = '{20, 20, 6};
  int          sva[3] = '{5, 9, 9};

  always #2.5 CLK = ~CLK;

  ptc_timer #(.BASE_TICK_CYCLES(TICK)) i_dut (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .START_IN(pins.start), .GATE_IN(pins.gate), .RESET_A_IN(pins.rst_a),
    .RESET_B_IN(pins.rst_b), .RESET_KEY(pins.key_rst), .UP_KEY(pins.key_up),
    .MODE_KEY(pins.key_mode), .KEY_PROTECT_SW(pins.kp_sw), .FIRST_OUTPUT(FIRST_OUTPUT),
    .SECOND_OUTPUT(SECOND_OUTPUT), .OUT_IND(OUT_IND), .RESET_IND(RESET_IND),
    .KEY_PROT_IND(KEY_PROT_IND), .PV_DP(PV_DP), .UP_KEY_OK(UP_KEY_OK),
    .MODE_KEY_OK(MODE_KEY_OK));
  ptc_pins_model i_pins (.clk(CLK), .cmd(cmd), .slow(slow), .pins(pins));

  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected {first, second, indicator[1:0], reset ind, protect ind, up ok, mode ok}
  function automatic logic [7:0] ex(input logic f, s, r, k, u, m);
    return {f, s, s, f, r, k, u, m};
  endfunction
  task automatic bad(input string msg);
    fails++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask
  task automatic cmp_rd(input logic [32:0] e);
    comparisons++;
    if ({PSLVERR, PRDATA} !== e) bad($sformatf("read %h want %h", {PSLVERR, PRDATA}, e));
  endtask
  task automatic cmp_pin(input logic [7:0] e);
    logic [7:0] o;
    o = {FIRST_OUTPUT, SECOND_OUTPUT, OUT_IND, RESET_IND, KEY_PROT_IND, UP_KEY_OK, MODE_KEY_OK};
    comparisons++;
    if (o !== e) bad($sformatf("outputs %b want %b", o, e));
  endtask
  task automatic cmp_flag(input logic got, input string what);
    comparisons++;
    if (got !== 1'b1) bad(what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // one APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic c, input logic [32:0] e);
    int n;
    n = 0;
    if (c) rd_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    rd_chk <= c;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 40) begin
      @(posedge CLK);
      n++;
    end
    if (n == 40) bad("no ready");
    rd_val = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    rd_chk <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, 1'b1, e);
  endtask
  task automatic chk(input logic [7:0] e);
    pin_q.push_back(e);
    pin_chk <= 1'b1;
    @(posedge CLK);
    pin_chk <= 1'b0;
    @(posedge CLK);
  endtask
  // pulse a terminal long enough to pass the model and the synchroniser
  task automatic clr();
    cmd.rst_a <= 1'b1;
    cyc(6);
    cmd.rst_a <= 1'b0;
    cyc(6);
  endtask
  task automatic go();
    cmd.start <= 1'b1;
    cyc(6);
    cmd.start <= 1'b0;
    cyc(1);
  endtask
  task automatic dp_watch(input int n);
    dp_chg = 0;
    dp_p = PV_DP;
    repeat (n) begin
      @(posedge CLK);
      if (PV_DP !== dp_p) dp_chg++;
      dp_p = PV_DP;
    end
  endtask
  task automatic results();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watcher: takes the oldest note whenever a result shows
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE && rd_chk) cmp_rd(rd_q.pop_front());
    if (pin_chk) cmp_pin(pin_q.pop_front());
  end

  initial begin
    cyc(5);
    RSTN <= 1'b1;
    cyc(3);
    // reset values, unmapped and read-only places
    rd(OFS_CTRL, 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    wr(OFS_PV, 32'h000FFFFF);
    rd(OFS_PV, 33'h0);
    rd(OFS_STATUS, 33'h20);
    chk(ex(0, 0, 0, 0, 0, 0));
    // thresholds in both setting methods, frozen by the gate at random times
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL, (m == 1) ? 32'h3 : 32'h2);
      wr(OFS_SVMAIN, 32'(svm[m]));
      wr(OFS_SVAUX, 32'(sva[m]));
      thr2 = svm[m];
      thr1 = (m == 1) ? sva[m] : ((sva[m] >= svm[m]) ? 0 : svm[m] - sva[m]);
      for (int k = 0; k < 4; k++) begin
        clr();
        go();
        rnd = step(rnd);
        slow <= rnd[0];
        cyc(int'(rnd[6:0]));
        cmd.gate <= 1'b1;
        cyc(8);
        apb(1'b0, OFS_PV, 32'h0, 1'b0, 33'h0);
        cyc(12);
        rd(OFS_PV, {1'b0, rd_val});
        chk(ex(rd_val >= thr1, rd_val >= thr2, 0, 0, 0, 0));
        cmd.gate <= 1'b0;
        cyc(1);
      end
    end
    // each reset source in turn: A terminal, B terminal, reset key
    for (int r = 0; r < 3; r++) begin
      clr();
      go();
      cyc(60);
      chk(ex(1, 1, 0, 0, 0, 0));
      cmd <= ptc_pins_s'(cmd | (8'h20 >> r));
      cyc(6);
      chk(ex(0, 0, 1, 0, 0, 0));
      rd(OFS_PV, 33'h0);
      cyc(20);
      rd(OFS_PV, 33'h0);
      cmd <= ptc_pins_s'(cmd & ~(8'h20 >> r));
      cyc(6);
      chk(ex(0, 0, 0, 0, 0, 0));
      rd(OFS_STATUS, 33'h0);
    end
    // key protection, then the switch turned off while running
    wr(OFS_CTRL, 32'h3A);
    rd(OFS_CTRL, 33'h3A);
    wr(OFS_SVMAIN, 32'd100);
    rd(OFS_SVMAIN, 33'd100);
    wr(OFS_SVAUX, 32'd50);
    clr();
    go();
    cyc(40);
    cmd <= ptc_pins_s'(cmd | 8'h0F);
    cyc(6);
    chk(ex(0, 0, 0, 1, 0, 0));
    apb(1'b0, OFS_PV, 32'h0, 1'b0, 33'h0);
    cmp_flag(rd_val[19:0] != 20'h0, "protected key cleared count");
    cmd.kp_sw <= 1'b0;
    cyc(6);
    chk(ex(0, 0, 1, 0, 1, 1));
    rd(OFS_PV, 33'h0);
    cmd <= ptc_pins_s'(cmd & 8'hF0);
    cyc(6);
    // decimal point: blinks in the tenth-minute range, dark in the seconds range
    wr(OFS_CTRL, 32'h6);
    clr();
    go();
    dp_watch(500);
    cmp_flag(dp_chg >= 2, "point not blinking");
    wr(OFS_CTRL, 32'h4);
    clr();
    go();
    dp_watch(500);
    cmp_flag(dp_chg == 0 && PV_DP === 1'b0, "point lit");
    // one count per 100 base steps of 4 cycles: one count after about 500 cycles
    rd(OFS_PV, 33'h1);
    results();
  end

  // hang guard: the tests need well under 5000 cycles
  initial begin
    #100000;
    bad("watchdog");
    results();
  end
endmodule
